/* rtl/csw2_status_word.sv */
// Communication and math status word with Wishbone register access.
// Assumes one clock, synchronous reset, and event inputs on the same clock.
//
// Behaviour
// - Incoming-request flag sets whenever a remote node asks or commands.
// - Incoming-request flag clears when the request has been serviced.
// - Reply-waiting flag sets when the remote reply arrives.
// - Reply-waiting flag clears once reply is stored and instruction updated.
// - Outgoing-waiting flag sets while messages queue and nothing transmits.
// - Outgoing flag clears on transmit start; resets after only if more queued.
// - Overflow-select resets to zero, giving saturating overflow by default.
// - Unrepresentable add, subtract, multiply or divide sets the overflow flag.
// - Same overflow also sets the trap bit 0 of the minor-error word.
// - Overflow-select set writes the truncated low 16 bits to the destination.
// - Overflow-select clear saturates destination to 32767 or -32768.
// - Double divide ignores overflow-select entirely.
// - Math register written by multiply and divide ignores overflow-select.
// - Minor bits clear at reset; any of bits 7:0 set at scan end raise major 0020H.
`timescale 1ns/100ps
`include "csw2_cfg.svh"

module csw2_status_word #(
   parameter int ADDR_W = 8
) (
   // Clock and reset.
   input  wire logic                 mclk,
   input  wire logic                 rst,
   // Wishbone slave.
   input  wire logic                 wbCyc,
   input  wire logic                 wbStb,
   input  wire logic                 wbWe,
   input  wire logic [ADDR_W-1:0]    wbAdr,
   input  wire logic [3:0]           wbSel,
   input  wire logic [31:0]          wbDatIn,
   output logic      [31:0]          wbDatOut,
   output logic                      wbAck,
   // Network and executor events.
   input  wire csw2_pkg::csw2_comm_t comm,
   input  wire logic                 scanEnd,
   // Arithmetic request and answer.
   input  wire csw2_pkg::csw2_math_req_t mathReq,
   output logic                      resValid,
   output logic      [15:0]          resDest,
   output logic      [31:0]          mathReg,
   output logic                      ovfFlag,
   // Status outputs.
   output logic      [15:0]          statusWord,
   output logic      [15:0]          minorWord,
   output logic                      majorFault,
   output logic      [15:0]          majorCode,
   output logic                      irq
);

   //----------------------------------------------------------------
   // Parameter check
   //----------------------------------------------------------------

   // The word index needs address bits 4 down to 2.
   if (ADDR_W < 5) begin : g_chk
      $error("ADDR_W must be at least 5");
   end

   //----------------------------------------------------------------
   // State
   //----------------------------------------------------------------

   csw2_pkg::csw2_state_t s_r;
   csw2_pkg::csw2_state_t s_nxt;

   logic [5:0]         wordIdx;
   logic               busReq;
   logic               busWr;
   logic               busRd;
   logic signed [32:0] full;
   logic               divZero;
   logic               negRes;
   logic               overflow;
   logic [15:0]        statusView;
   logic [3:0]         irqSet;

   // Word index taken from the byte address, unused upper bits ignored.
   assign wordIdx = 6'(wbAdr[ADDR_W-1:2]);
   assign busReq  = wbCyc & wbStb & ~s_r.ack;
   assign busWr   = busReq & wbWe;
   assign busRd   = busReq & ~wbWe;

   // Status word as software sees it; all other positions are zero.
   always_comb begin
      statusView = 16'h0000;
      statusView[`CSW2_BIT_INREQ]  = s_r.inReq;
      statusView[`CSW2_BIT_REPLY]  = s_r.reply;
      statusView[`CSW2_BIT_OUTW]   = s_r.outWait;
      statusView[`CSW2_BIT_OVFSEL] = s_r.ovfSel;
   end

   //----------------------------------------------------------------
   // Arithmetic
   //----------------------------------------------------------------

   // Full-width result, then representability in a signed 16-bit word.
   always_comb begin
      full    = '0;
      divZero = 1'b0;
      unique case (mathReq.op)
         csw2_pkg::OP_ADD: begin
            full = 33'(mathReq.a) + 33'(mathReq.b);
         end
         csw2_pkg::OP_SUB: begin
            full = 33'(mathReq.a) - 33'(mathReq.b);
         end
         csw2_pkg::OP_MUL: begin
            full = 33'(mathReq.a) * 33'(mathReq.b);
         end
         csw2_pkg::OP_DIV: begin
            divZero = (mathReq.b == 16'sh0000);
            if (!divZero) begin
               full = 33'(mathReq.a) / 33'(mathReq.b);
            end
         end
         csw2_pkg::OP_DDIV: begin
            divZero = (mathReq.b == 16'sh0000);
            if (!divZero) begin
               full = 33'(mathReq.dividend) / 33'(mathReq.b);
            end
         end
         default: begin
            full = '0;
         end
      endcase
   end

   // Divide by zero takes the dividend's sign for saturation.
   always_comb begin
      if (divZero) begin
         negRes = (mathReq.op == csw2_pkg::OP_DDIV) ? mathReq.dividend[31] : mathReq.a[15];
      end else begin
         negRes = full[32];
      end
      overflow = divZero | (full > 33'sh0_0000_7fff) | (full < -33'sh0_0000_8000);
   end

   //----------------------------------------------------------------
   // Next state
   //----------------------------------------------------------------

   // One pass computes every field of the next state.
   always_comb begin
      s_nxt    = s_r;
      irqSet   = 4'h0;
      s_nxt.resValid = 1'b0;

      // Incoming request; an arrival in the service cycle is kept.
      if (comm.reqArrive) begin
         s_nxt.inReq = 1'b1;
      end else if (comm.reqServiced) begin
         s_nxt.inReq = 1'b0;
      end
      irqSet[`CSW2_IRQ_INREQ] = comm.reqArrive & ~s_r.inReq;

      // Reply waiting, same set-over-clear priority.
      if (comm.replyArrive) begin
         s_nxt.reply = 1'b1;
      end else if (comm.replyStored) begin
         s_nxt.reply = 1'b0;
      end
      irqSet[`CSW2_IRQ_REPLY] = comm.replyArrive & ~s_r.reply;

      // Transmitter busy from start to done.
      if (comm.txStart) begin
         s_nxt.txBusy = 1'b1;
      end else if (comm.txDone) begin
         s_nxt.txBusy = 1'b0;
      end
      // Outgoing waiting follows queue and transmitter.
      s_nxt.outWait = comm.msgQueued & ~s_nxt.txBusy;

      // Arithmetic answer.
      if (mathReq.valid) begin
         s_nxt.resValid = 1'b1;
         s_nxt.ovfFlag  = overflow;
         if (!overflow) begin
            s_nxt.dest = full[15:0];
         end else if (s_r.ovfSel && (mathReq.op != csw2_pkg::OP_DDIV)) begin
            s_nxt.dest = full[15:0];
         end else begin
            s_nxt.dest = negRes ? `CSW2_SAT_NEG : `CSW2_SAT_POS;
         end
         // Math register never looks at overflow-select.
         unique case (mathReq.op)
            csw2_pkg::OP_MUL: begin
               s_nxt.mathReg = full[31:0];
            end
            csw2_pkg::OP_DIV: begin
               s_nxt.mathReg = full[31:0];
            end
            csw2_pkg::OP_DDIV: begin
               s_nxt.mathReg = full[31:0];
            end
            default: begin
               s_nxt.mathReg = s_r.mathReg;
            end
         endcase
      end

      // Bus write side: ack one cycle after the request.
      s_nxt.ack  = busReq;
      s_nxt.rdat = 32'h0000_0000;
      if (busWr) begin
         unique case (wordIdx)
            `CSW2_IDX_STATUS: begin
               if (wbSel[1]) begin
                  s_nxt.ovfSel = wbDatIn[`CSW2_BIT_OVFSEL];
               end
            end
            `CSW2_IDX_IRQMSK: begin
               if (wbSel[0]) begin
                  s_nxt.irqMask = wbDatIn[3:0];
               end
            end
            `CSW2_IDX_MINOR: begin
               if (wbSel[0]) begin
                  s_nxt.minor[7:0] = wbDatIn[7:0];
               end
               if (wbSel[1]) begin
                  s_nxt.minor[15:8] = wbDatIn[15:8];
               end
            end
            `CSW2_IDX_MAJOR: begin
               if (wbSel[0]) begin
                  s_nxt.majCode[7:0] = wbDatIn[7:0];
               end
               if (wbSel[1]) begin
                  s_nxt.majCode[15:8] = wbDatIn[15:8];
               end
               s_nxt.fault = 1'b0;
            end
            default: begin
               s_nxt.rdat = 32'h0000_0000;
            end
         endcase
      end

      // Bus read side; status interrupts clear on read.
      if (busRd) begin
         unique case (wordIdx)
            `CSW2_IDX_STATUS: s_nxt.rdat = {16'h0000, statusView};
            `CSW2_IDX_IRQST: begin
               s_nxt.rdat  = {28'h0000000, s_r.irqSt};
               s_nxt.irqSt = 4'h0;
            end
            `CSW2_IDX_IRQMSK: s_nxt.rdat = {28'h0000000, s_r.irqMask};
            `CSW2_IDX_MINOR:  s_nxt.rdat = {16'h0000, s_r.minor};
            `CSW2_IDX_MAJOR:  s_nxt.rdat = {15'h0000, s_r.fault, s_r.majCode};
            default:          s_nxt.rdat = 32'h0000_0000;
         endcase
      end

      // Hardware sets come after software writes so they win.
      if (mathReq.valid && overflow) begin
         s_nxt.minor[0] = 1'b1;
         irqSet[`CSW2_IRQ_TRAP] = 1'b1;
      end
      if (scanEnd && (s_nxt.minor[7:0] != 8'h00)) begin
         s_nxt.fault   = 1'b1;
         s_nxt.majCode = `CSW2_MAJ_MINOR;
         irqSet[`CSW2_IRQ_FAULT] = 1'b1;
      end
      s_nxt.irqSt = s_nxt.irqSt | irqSet;
      s_nxt.irq   = |(s_nxt.irqSt & s_nxt.irqMask);
   end

   //----------------------------------------------------------------
   // Registers
   //----------------------------------------------------------------

   // Synchronous reset to constants, otherwise take the next state.
   always_ff @(posedge mclk) begin
      if (rst) begin
         s_r         <= '0;
         s_r.ovfSel  <= `CSW2_RST_OVFSEL;
         s_r.minor   <= 16'h0000;
         s_r.irqMask <= `CSW2_RST_MASK;
      end else begin
         s_r <= s_nxt;
      end
   end

   //----------------------------------------------------------------
   // Outputs
   //----------------------------------------------------------------

   // Every output is a field of the state register.
   assign wbDatOut   = s_r.rdat;
   assign wbAck      = s_r.ack;
   assign resValid   = s_r.resValid;
   assign resDest    = s_r.dest;
   assign mathReg    = s_r.mathReg;
   assign ovfFlag    = s_r.ovfFlag;
   assign minorWord  = s_r.minor;
   assign majorFault = s_r.fault;
   assign majorCode  = s_r.majCode;
   assign irq        = s_r.irq;

   // Status word port mirrors the flops directly.
   assign statusWord = {1'b0, s_r.ovfSel, 6'h00, s_r.outWait, s_r.reply, s_r.inReq, 5'h00};

endmodule

/* rtl/csw2_cfg.svh */
// Offsets, field positions, reset values and fixed codes for the status word block.
// Assumes inclusion by bare name from the top module.
`ifndef CSW2_CFG_SVH
`define CSW2_CFG_SVH
// Word indices; the byte address is four times the index.
`define CSW2_IDX_STATUS 6'h02
`define CSW2_IDX_IRQST  6'h03
`define CSW2_IDX_IRQMSK 6'h04
`define CSW2_IDX_MINOR  6'h05
`define CSW2_IDX_MAJOR  6'h06
// Status word field positions.
`define CSW2_BIT_INREQ  5
`define CSW2_BIT_REPLY  6
`define CSW2_BIT_OUTW   7
`define CSW2_BIT_OVFSEL 14
// Interrupt status bit positions.
`define CSW2_IRQ_INREQ  0
`define CSW2_IRQ_REPLY  1
`define CSW2_IRQ_TRAP   2
`define CSW2_IRQ_FAULT  3
// Reset values and fixed codes.
`define CSW2_RST_OVFSEL 1'h0
`define CSW2_RST_MASK   4'h0
`define CSW2_MAJ_MINOR  16'h0020
`define CSW2_SAT_POS    16'h7fff
`define CSW2_SAT_NEG    16'h8000
`endif

/* rtl/csw2_pkg.sv */
// Types shared by the status word block.
// Assumes the constants header sits beside it.
package csw2_pkg;
   // Arithmetic operations offered by the executor.
   typedef enum logic [2:0] {
      OP_ADD,
      OP_SUB,
      OP_MUL,
      OP_DIV,
      OP_DDIV
   } csw2_op_t;
   // One arithmetic request, valid for one cycle.
   typedef struct packed {
      logic               valid;
      csw2_op_t           op;
      logic signed [15:0] a;
      logic signed [15:0] b;
      logic signed [31:0] dividend;
   } csw2_math_req_t;
   // Communication events, each a one-cycle pulse except queued.
   typedef struct packed {
      logic reqArrive;
      logic reqServiced;
      logic replyArrive;
      logic replyStored;
      logic msgQueued;
      logic txStart;
      logic txDone;
   } csw2_comm_t;
   // Whole state of the top module.
   typedef struct packed {
      logic        inReq;
      logic        reply;
      logic        outWait;
      logic        txBusy;
      logic        ovfSel;
      logic        ovfFlag;
      logic [15:0] minor;
      logic [15:0] majCode;
      logic        fault;
      logic [3:0]  irqSt;
      logic [3:0]  irqMask;
      logic        irq;
      logic        ack;
      logic [31:0] rdat;
      logic        resValid;
      logic [15:0] dest;
      logic [31:0] mathReg;
   } csw2_state_t;
endpackage

/* bench/csw2_far_model.sv */
// Far-side model: remote network nodes and the instruction executor.
// Assumes the bench calls its tasks and shares the block's clock.
`timescale 1ns/100ps

module csw2_far_model (
   // Clock.
   input  wire logic                mclk,
   // Towards the block.
   output csw2_pkg::csw2_comm_t     comm,
   output csw2_pkg::csw2_math_req_t mathReq
);
   // ----------
   // Queue and event pulses
   // ----------
   int pending;

   // Idle values at time zero.
   initial begin
      pending = 0;
      comm = '0;
      mathReq = '0;
   end

   // The queued level follows the count of waiting messages.
   always @(posedge mclk) begin
      comm.msgQueued <= (pending != 0);
   end

   // One-cycle pulse on one event bit.
   task automatic pulse(input int b);
      @(posedge mclk);
      comm[b] <= 1'h1;
      @(posedge mclk);
      comm[b] <= 1'h0;
   endtask

   // One arithmetic request, valid for one cycle.
   task automatic math(input csw2_pkg::csw2_op_t o, input logic [15:0] a,
                       input logic [15:0] b, input logic [31:0] d);
      @(posedge mclk);
      mathReq <= {1'h1, o, a, b, d};
      @(posedge mclk);
      mathReq.valid <= 1'h0;
   endtask
endmodule

/* bench/csw2_status_word_chk.sv */
// Checker of the status word block, watching its ports only.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps

module csw2_status_word_chk #(
   parameter int ADDR_W = 8
) (
   // Clock and reset.
   input wire logic                     mclk,
   input wire logic                     rst,
   // Bus.
   input wire logic                     wbCyc,
   input wire logic                     wbStb,
   input wire logic                     wbWe,
   input wire logic [ADDR_W-1:0]        wbAdr,
   input wire logic [3:0]               wbSel,
   input wire logic [31:0]              wbDatIn,
   input wire logic [31:0]              wbDatOut,
   input wire logic                     wbAck,
   // Events and arithmetic.
   input wire csw2_pkg::csw2_comm_t     comm,
   input wire logic                     scanEnd,
   input wire csw2_pkg::csw2_math_req_t mathReq,
   input wire logic                     resValid,
   input wire logic [15:0]              resDest,
   input wire logic [31:0]              mathReg,
   input wire logic                     ovfFlag,
   // Status.
   input wire logic [15:0]              statusWord,
   input wire logic [15:0]              minorWord,
   input wire logic                     majorFault,
   input wire logic [15:0]              majorCode,
   input wire logic                     irq
);
   // ----------
   // Helpers and properties
   // ----------
   logic selPrev;
   wire  satHit = resDest == 16'h7fff || resDest == 16'h8000;
   wire  minorHit = minorWord[7:0] != 8'h00;
   wire  majGood = majorFault && majorCode == 16'h0020;

   // Overflow select as seen when the operation was taken.
   always_ff @(posedge mclk) begin
      selPrev <= statusWord[14];
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   a_ack_once: assert property (wbCyc && wbStb && !wbAck |=> wbAck ##1 !wbAck)
      else $error("bus acknowledge malformed");
   a_req_set: assert property (comm.reqArrive |=> statusWord[5])
      else $error("incoming flag not set");
   a_req_clear: assert property (comm.reqServiced && !comm.reqArrive |=> !statusWord[5])
      else $error("incoming flag not cleared");
   a_rep_set: assert property (comm.replyArrive |=> statusWord[6])
      else $error("reply flag not set");
   a_rep_clear: assert property (comm.replyStored && !comm.replyArrive |=> !statusWord[6])
      else $error("reply flag not cleared");
   a_tx_clears: assert property (comm.txStart |=> ##[0:1] !statusWord[7])
      else $error("outgoing flag kept at start");
   a_sel_reset: assert property ($fell(rst) |-> !statusWord[14])
      else $error("overflow select not reset");
   a_trap_minor: assert property (resValid && ovfFlag |-> minorWord[0])
      else $error("overflow trap missing");
   a_sat_limit: assert property (resValid && ovfFlag && !selPrev |-> satHit)
      else $error("saturation value wrong");
   a_scan_major: assert property (scanEnd && minorHit |=> majGood)
      else $error("major fault not raised");
   a_rsvd_zero: assert property ((statusWord & 16'hbf00) == 16'h0000)
      else $error("reserved status bits set");

   // Main scenarios reached.
   cover property (resValid && ovfFlag && selPrev);
   cover property (statusWord[7]);
   cover property (majorFault);
endmodule

bind csw2_status_word csw2_status_word_chk #(.ADDR_W(ADDR_W)) chk_u (
   .mclk, .rst, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatIn, .wbDatOut, .wbAck, .comm,
   .scanEnd, .mathReq, .resValid, .resDest, .mathReg, .ovfFlag, .statusWord, .minorWord,
   .majorFault, .majorCode, .irq
);

/* bench/tb.sv */
// Self-checking bench for the communication and math status word.
// Assumes the far-side model drives events and arithmetic requests.
`timescale 1ns/100ps

`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
   $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e); end end

module tb;
   // ----------
   // Signals and instances
   // ----------
   logic                     mclk = 1'h0;
   logic                     rst = 1'h1;
   logic                     wbCyc, wbStb, wbWe, scanEnd, wbAck, resValid, ovfFlag;
   logic                     majorFault, irq;
   logic [7:0]               wbAdr;
   logic [3:0]               wbSel;
   logic [3:0]               laneSel = 4'hf;
   logic [31:0]              wbDatIn, wbDatOut, mathReg, rv;
   logic [15:0]              resDest, statusWord, minorWord, majorCode;
   csw2_pkg::csw2_comm_t     comm;
   csw2_pkg::csw2_math_req_t mathReq;
   int                       failures = 0;
   int                       checked = 0;

   // Clock of 25 ns.
   always #12.5 mclk = ~mclk;

   csw2_status_word #(.ADDR_W(8)) dut_u (
      .mclk, .rst, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatIn, .wbDatOut,
      .wbAck, .comm, .scanEnd, .mathReq, .resValid, .resDest, .mathReg, .ovfFlag,
      .statusWord, .minorWord, .majorFault, .majorCode, .irq);
   csw2_far_model pm_u (.mclk, .comm, .mathReq);

   // One classic bus cycle; read data lands in rv; only the watchdog ends a hung wait.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      wbCyc <= 1'h1;
      wbStb <= 1'h1;
      wbWe <= w;
      wbAdr <= a;
      wbSel <= laneSel;
      wbDatIn <= d;
      do begin
         @(posedge mclk);
      end while (wbAck !== 1'h1);
      rv = wbDatOut;
      wbCyc <= 1'h0;
      wbStb <= 1'h0;
   endtask

   // Status word reset value, reserved bits and an unmapped place.
   task automatic t_regs;
      bus(1'h0, 8'h08, 32'h0);
      `CHK(rv, 32'h0)
      bus(1'h1, 8'h08, 32'hffffffff);
      bus(1'h0, 8'h08, 32'h0);
      `CHK(rv, 32'h00004000)
      // A write without byte lane 1 must leave the selection alone.
      laneSel = 4'hd;
      bus(1'h1, 8'h08, 32'h0);
      laneSel = 4'hf;
      bus(1'h0, 8'h08, 32'h0);
      `CHK(rv, 32'h00004000)
      bus(1'h1, 8'h08, 32'h0);
      bus(1'h0, 8'h1c, 32'h0);
      `CHK(rv, 32'h0)
   endtask

   // Remote request and reply flags with the interrupt path.
   task automatic t_comm;
      bus(1'h1, 8'h10, 32'h1);
      pm_u.pulse(6);
      @(negedge mclk);
      `CHK(statusWord[5], 1'h1)
      repeat (2) @(negedge mclk);
      `CHK(irq, 1'h1)
      bus(1'h0, 8'h0c, 32'h0);
      `CHK(rv, 32'h1)
      repeat (2) @(negedge mclk);
      `CHK(irq, 1'h0)
      pm_u.pulse(5);
      @(negedge mclk);
      `CHK(statusWord[5], 1'h0)
      pm_u.pulse(4);
      @(negedge mclk);
      `CHK(statusWord[6], 1'h1)
      pm_u.pulse(3);
      @(negedge mclk);
      `CHK(statusWord[6], 1'h0)
      `CHK(irq, 1'h0)
      bus(1'h0, 8'h0c, 32'h0);
      `CHK(rv, 32'h2)
   endtask

   // Two queued messages sent one after the other.
   task automatic t_queue;
      pm_u.pending = 2;
      repeat (3) @(negedge mclk);
      `CHK(statusWord[7], 1'h1)
      for (int k = 1; k >= 0; k--) begin
         pm_u.pulse(1);
         pm_u.pending--;
         repeat (2) @(negedge mclk);
         `CHK(statusWord[7], 1'h0)
         pm_u.pulse(0);
         repeat (3) @(negedge mclk);
         `CHK(statusWord[7], k == 1)
      end
   endtask

   // One operation and its destination and overflow answer.
   task automatic doop(input csw2_pkg::csw2_op_t o, input logic [15:0] a, input logic [15:0] b,
                       input logic [31:0] d, input logic [15:0] e, input logic v);
      pm_u.math(o, a, b, d);
      @(negedge mclk);
      `CHK(resValid, 1'h1)
      `CHK(resDest, e)
      `CHK(ovfFlag, v)
   endtask

   // Every operation overflowing under both overflow selections.
   task automatic t_math;
      for (int s = 0; s < 2; s++) begin
         bus(1'h1, 8'h08, s ? 32'h4000 : 32'h0);
         doop(csw2_pkg::OP_ADD, 16'h7fff, 16'h1, 32'h0, s ? 16'h8000 : 16'h7fff, 1'h1);
         doop(csw2_pkg::OP_SUB, 16'h8000, 16'h1, 32'h0, s ? 16'h7fff : 16'h8000, 1'h1);
         doop(csw2_pkg::OP_MUL, 16'h100, 16'h100, 32'h0, s ? 16'h0 : 16'h7fff, 1'h1);
         `CHK(mathReg, 32'h00010000)
         doop(csw2_pkg::OP_DIV, 16'h8000, 16'hffff, 32'h0, s ? 16'h8000 : 16'h7fff, 1'h1);
         `CHK(mathReg, 32'h00008000)
         doop(csw2_pkg::OP_DDIV, 16'h0, 16'h10, 32'h00100000, 16'h7fff, 1'h1);
         doop(csw2_pkg::OP_ADD, 16'h7ffe, 16'h1, 32'h0, 16'h7fff, 1'h0);
      end
   endtask

   // Scan end turns a pending trap into a major fault once.
   task automatic t_scan;
      `CHK(minorWord[0], 1'h1)
      for (int k = 0; k < 2; k++) begin
         @(posedge mclk);
         scanEnd <= 1'h1;
         @(posedge mclk);
         scanEnd <= 1'h0;
         @(negedge mclk);
         `CHK(majorFault, k == 0)
         `CHK(majorCode, k ? 16'h0 : 16'h0020)
         bus(1'h0, 8'h18, 32'h0);
         `CHK(rv, k ? 32'h0 : 32'h00010020)
         bus(1'h1, 8'h14, 32'h0);
         bus(1'h1, 8'h18, 32'h0);
      end
   endtask

   // Mid-run reset drops a pending trap and the truncating selection.
   task automatic t_reset;
      doop(csw2_pkg::OP_ADD, 16'h7fff, 16'h1, 32'h0, 16'h8000, 1'h1);
      `CHK(minorWord[0], 1'h1)
      @(posedge mclk);
      rst <= 1'h1;
      repeat (2) @(posedge mclk);
      rst <= 1'h0;
      @(negedge mclk);
      `CHK(statusWord, 16'h0)
      `CHK(minorWord, 16'h0)
      `CHK(ovfFlag, 1'h0)
      bus(1'h0, 8'h08, 32'h0);
      `CHK(rv, 32'h0)
   endtask

   // Verdict and end of run.
   task automatic conclude;
      if (failures == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Main sequence.
   initial begin
      {wbCyc, wbStb, wbWe, scanEnd} = 4'h0;
      wbSel = 4'h0;
      wbAdr = 8'h0;
      wbDatIn = 32'h0;
      repeat (5) @(posedge mclk);
      rst <= 1'h0;
      t_regs();
      t_comm();
      t_queue();
      t_math();
      t_scan();
      t_reset();
      conclude();
   end

   // Cut a hung run short.
   initial begin
      #50000;
      failures++;
      conclude();
   end
endmodule
